// *** logic/buck_regs_pkg.sv ***
// Summary of operation
// [R01] status bits follow their live condition, high only while it holds
// [R02] flag bits set on their event and stay set until cleared
// [R03] output-low flag sets when output under 70% while current limited
// [R04] output-high flag sets when output exceeds regulation by 20%
// [R05] thermal trip flag sets when the over-temperature detector trips
// [R06] current limit flag sets when inductor current reaches its limit
// [R07] brown-out flag sets when feedback under 80% without current limit
// [R08] failed-start flag sets when feedback misses 90% by soft-start end
// [R09] power good is delayed by a tenth of the soft-start time
// [R10] discontinuous status high in DISCONTINUOUS_STATUS with power save, shutdown, soft start
// [R11] power good status high exactly while power good output is released
// [R12] switching_enable low holds switches off; start needs bit and pin high
// [R13] writing fault_clear clears the six flags; the bit reads back zero
// [R14] internal_load_enable turns on the output pull-down while slewing down
// [R15] frequency code 00..11 selects 250k, 500k, 750k or 1 MHz
// [R16] power-on delay code selects 0, 250us, 500us, 1, 2, 4, 8, 16 ms
// [R17] soft-start code selects 250us to 8ms for 000..101, 16ms for 111
// [R18] power save code 01 low-iq, 10 ultrasonic, 00 and 11 off
// [R19] ultrasonic minimum frequency code is {reg3 bit5, reg2 bit5}
// [R20] undefined soft-start code 110 runs as the longest soft start
// [R21] a flag event in the cycle of a clear still sets the flag
package buck_regs_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_CTRL   = 8'h01;
	localparam logic [7:0] ADDR_TIME_A = 8'h02;
	localparam logic [7:0] ADDR_TIME_B = 8'h03;
	localparam logic [7:0] RST_CTRL    = 8'h01;
	localparam logic [7:0] RST_TIME_A  = 8'h20;
	localparam logic [7:0] RST_TIME_B  = 8'h2e;
	localparam int BIT_SW_EN   = 0;
	localparam int BIT_CLEAR   = 1;
	localparam int BIT_IL_EN   = 2;
	localparam int BIT_ULTRASONIC_MIN_FREQ_SELECT    = 5;
	localparam int FLD_LO      = 2;
	localparam int FLD_HI      = 4;
	localparam int FLAG_UV     = 0;
	localparam int FLAG_OV     = 1;
	localparam int FLAG_OT     = 2;
	localparam int FLAG_CURRENT_LIMIT_FLAG   = 3;
	localparam int FLAG_BO     = 4;
	localparam int FLAG_DNS    = 5;
	localparam int NFLAGS      = 6;
	localparam int STAT_DCM    = 6;
	localparam int STAT_PG     = 7;
	localparam int PIN_UV70    = 0;
	localparam int PIN_CURRENT_LIMIT_FLAG    = 1;
	localparam int PIN_OV120   = 2;
	localparam int PIN_OT      = 3;
	localparam int PIN_FB80    = 4;
	localparam int PIN_FB90    = 5;
	localparam int PIN_PGWIN   = 6;
	localparam int PIN_DCM     = 7;
	localparam int PIN_EN      = 8;
	localparam int PIN_SLEW    = 9;
	localparam int NPINS       = 10;
	localparam logic [1:0] PSV_LOWIQ = 2'h1;
	localparam logic [1:0] PSV_ULTRA = 2'h2;
	localparam logic [2:0] SST_MAXSHIFT = 3'h5;
	localparam logic [6:0] SST_LONGEST  = 7'h40;
	localparam int CLOCK_PERIOD_NS = 10;
	localparam int STEP_TIME_US    = 250;
	localparam int STEP_CYCLES     = (STEP_TIME_US * 1000) / CLOCK_PERIOD_NS;
	localparam int PG_DELAY_DIV    = 10;
	localparam int TMR_W           = 24;
	localparam int MAX_STEPS       = 64;
endpackage

// *** logic/buck_ctrl_status_timing_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module buck_ctrl_status_timing_regs #(
	parameter int UNIT_CYCLES = buck_regs_pkg::STEP_CYCLES
) (
	input  wire logic                        clock,
	input  wire logic                        rst_b,
	input  wire logic                        reg_wr,
	input  wire logic [buck_regs_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [buck_regs_pkg::DATA_W-1:0] reg_wdata,
	output logic      [buck_regs_pkg::DATA_W-1:0] reg_rdata,
	input  wire logic                        out_below_70,
	input  wire logic                        current_limit_hit,
	input  wire logic                        out_above_120,
	input  wire logic                        thermal_trip,
	input  wire logic                        fb_below_80,
	input  wire logic                        fb_above_90,
	input  wire logic                        out_in_window,
	input  wire logic                        zero_cross_dcm,
	input  wire logic                        enable_pin,
	input  wire logic                        slewing_down,
	output logic                             switch_allow,
	output logic                             soft_start_active,
	output logic                             power_good,
	output logic                             internal_load_on,
	output logic      [1:0]                  freq_select,
	output logic                             low_iq_power_save,
	output logic                             ultrasonic_power_save,
	output logic      [1:0]                  ultrasonic_min_freq_select
);
	import buck_regs_pkg::*;

	if (UNIT_CYCLES < PG_DELAY_DIV || UNIT_CYCLES * MAX_STEPS >= 2 ** TMR_W) begin : g_bad_unit
		$error("UNIT_CYCLES out of the range the timers can serve");
	end

	localparam logic [TMR_W-1:0] UNIT_T = TMR_W'(UNIT_CYCLES);
	localparam logic [TMR_W-1:0] PG_UNIT_T = TMR_W'(UNIT_CYCLES / PG_DELAY_DIV);

	typedef enum logic [1:0] {SEQ_OFF, SEQ_POD, SEQ_SOFT, SEQ_RUN} seq_e;

	typedef struct packed {
		logic [NPINS-1:0]  meta;
		logic [NPINS-1:0]  pin;
		logic [NFLAGS-1:0] flags;
		logic              sw_en;
		logic              il_en;
		logic [5:0]        time_a;
		logic [5:0]        time_b;
		seq_e              seq;
		logic [TMR_W-1:0]  tmr;
		logic              fb_seen;
		logic [TMR_W-1:0]  pg_tmr;
		logic              pg_rel;
		logic [DATA_W-1:0] rdata;
	} state_s;

	localparam state_s RESET_STATE = '{
		meta:    '0,
		pin:     '0,
		flags:   '0,
		sw_en:   RST_CTRL[BIT_SW_EN],
		il_en:   RST_CTRL[BIT_IL_EN],
		time_a:  RST_TIME_A[5:0],
		time_b:  RST_TIME_B[5:0],
		seq:     SEQ_OFF,
		tmr:     '0,
		fb_seen: 1'b0,
		pg_tmr:  '0,
		pg_rel:  1'b0,
		rdata:   '0
	};

	state_s q;
	state_s d;

	logic [NPINS-1:0]  pins_raw;
	logic [NFLAGS-1:0] flag_set;
	logic              fault_clear_wr;
	logic              start_ok;
	logic              ps_enabled;
	logic [6:0]        pod_steps;
	logic [6:0]        ss_steps;
	logic [TMR_W-1:0]  pod_target;
	logic [TMR_W-1:0]  ss_target;
	logic [TMR_W-1:0]  pg_target;
	logic [DATA_W-1:0] status_word;
	logic [2:0]        pod_code;
	logic [2:0]        ss_code;

	assign pins_raw = {slewing_down, enable_pin, zero_cross_dcm, out_in_window, fb_above_90,
		fb_below_80, thermal_trip, out_above_120, current_limit_hit, out_below_70};

	// timing decode, in steps of the base delay
	assign pod_code = q.time_a[FLD_HI:FLD_LO];
	assign ss_code  = q.time_b[FLD_HI:FLD_LO];

	always_comb begin
		pod_steps = '0;
		if (pod_code != 3'h0) begin
			pod_steps = 7'(7'h01 << (pod_code - 3'h1)); // R16
		end
		if (ss_code <= SST_MAXSHIFT) begin
			ss_steps = 7'(7'h01 << ss_code); // R17
		end else begin
			ss_steps = SST_LONGEST; // R17 R20
		end
	end

	assign pod_target = TMR_W'(pod_steps * UNIT_T);
	assign ss_target  = TMR_W'(ss_steps * UNIT_T);
	assign pg_target  = TMR_W'(ss_steps * PG_UNIT_T); // R09

	assign ps_enabled = (q.time_b[1:0] == PSV_LOWIQ) || (q.time_b[1:0] == PSV_ULTRA); // R18
	assign start_ok   = q.sw_en && q.pin[PIN_EN]; // R12

	assign fault_clear_wr = reg_wr && (reg_addr == ADDR_CTRL) && reg_wdata[BIT_CLEAR];

	// fault events from the synchronised comparators
	always_comb begin
		flag_set = '0;
		flag_set[FLAG_UV]   = q.pin[PIN_UV70] && q.pin[PIN_CURRENT_LIMIT_FLAG]; // R03
		flag_set[FLAG_OV]   = q.pin[PIN_OV120]; // R04
		flag_set[FLAG_OT]   = q.pin[PIN_OT]; // R05
		flag_set[FLAG_CURRENT_LIMIT_FLAG] = q.pin[PIN_CURRENT_LIMIT_FLAG]; // R06
		flag_set[FLAG_BO]   = q.pin[PIN_FB80] && !q.pin[PIN_CURRENT_LIMIT_FLAG]; // R07
		flag_set[FLAG_DNS]  = (q.seq == SEQ_SOFT) && (q.tmr >= ss_target)
			&& !q.fb_seen && !q.pin[PIN_FB90]; // R08
	end

	always_comb begin
		status_word = '0;
		status_word[NFLAGS-1:0] = q.flags;
		status_word[STAT_DCM] = (q.seq != SEQ_RUN)
			|| (ps_enabled && q.pin[PIN_DCM]); // R01 R10
		status_word[STAT_PG] = q.pg_rel; // R11
	end

	always_comb begin
		d = q;
		// two-stage synchroniser for all analog-side levels
		d.meta = pins_raw;
		d.pin  = q.meta;

		// sticky flags, set wins over clear
		if (fault_clear_wr) begin
			d.flags = flag_set; // R13 R21
		end else begin
			d.flags = q.flags | flag_set; // R02
		end

		// register writes
		if (reg_wr) begin
			case (reg_addr)
				ADDR_CTRL: begin
					d.sw_en = reg_wdata[BIT_SW_EN];
					d.il_en = reg_wdata[BIT_IL_EN];
				end
				ADDR_TIME_A: begin
					d.time_a = reg_wdata[5:0];
				end
				ADDR_TIME_B: begin
					d.time_b = reg_wdata[5:0];
				end
				default: begin
					d.sw_en = q.sw_en;
				end
			endcase
		end

		// start-up sequencer
		case (q.seq)
			SEQ_OFF: begin
				d.tmr = '0;
				if (start_ok) begin
					d.seq = SEQ_POD; // R12
				end
			end
			SEQ_POD: begin
				if (q.tmr >= pod_target) begin
					d.seq = SEQ_SOFT;
					d.tmr = '0;
				end else begin
					d.tmr = q.tmr + 1'b1; // R16
				end
			end
			SEQ_SOFT: begin
				if (q.tmr >= ss_target) begin
					d.seq = SEQ_RUN; // R08
					d.tmr = '0;
				end else begin
					d.tmr = q.tmr + 1'b1; // R17
				end
			end
			SEQ_RUN: begin
				d.tmr = '0;
			end
			default: begin
				d.seq = SEQ_OFF;
				d.tmr = '0;
			end
		endcase
		if (!start_ok) begin
			d.seq = SEQ_OFF; // R12
			d.tmr = '0;
		end

		// power good delay and release
		if (q.seq == SEQ_SOFT || q.seq == SEQ_RUN) begin
			if (q.pin[PIN_FB90]) begin
				d.fb_seen = 1'b1;
			end
			if (q.fb_seen && q.pg_tmr < pg_target) begin
				d.pg_tmr = q.pg_tmr + 1'b1; // R09
			end
			d.pg_rel = q.fb_seen && (q.pg_tmr >= pg_target) && q.pin[PIN_PGWIN]; // R09 R11
		end else begin
			d.fb_seen = 1'b0;
			d.pg_tmr  = '0;
			d.pg_rel  = 1'b0;
		end

		// read data, one cycle after the address
		case (reg_addr)
			ADDR_STATUS: d.rdata = status_word;
			ADDR_CTRL:   d.rdata = DATA_W'({q.il_en, 1'b0, q.sw_en}); // R13
			ADDR_TIME_A: d.rdata = DATA_W'(q.time_a);
			ADDR_TIME_B: d.rdata = DATA_W'(q.time_b);
			default:     d.rdata = '0;
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			q <= RESET_STATE;
		end else begin
			q <= d;
		end
	end

	assign reg_rdata                  = q.rdata;
	assign switch_allow               = (q.seq == SEQ_SOFT) || (q.seq == SEQ_RUN); // R12
	assign soft_start_active          = (q.seq == SEQ_SOFT);
	assign power_good                 = q.pg_rel; // R11
	assign internal_load_on           = q.il_en && q.pin[PIN_SLEW]; // R14
	assign freq_select                = q.time_a[1:0]; // R15
	assign low_iq_power_save          = (q.time_b[1:0] == PSV_LOWIQ); // R18
	assign ultrasonic_power_save      = (q.time_b[1:0] == PSV_ULTRA); // R18
	assign ultrasonic_min_freq_select = {q.time_b[BIT_ULTRASONIC_MIN_FREQ_SELECT], q.time_a[BIT_ULTRASONIC_MIN_FREQ_SELECT]}; // R19

	// checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	property p_flag_sticky;
		!fault_clear_wr |=> ((q.flags & $past(q.flags)) == $past(q.flags));
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without clear"); // R02

	property p_set_wins;
		(|flag_set) |=> ((q.flags & $past(flag_set)) == $past(flag_set));
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("flag event lost"); // R21

	property p_clear_flags;
		(fault_clear_wr && flag_set == '0) |=> (q.flags == '0) ##1 (reg_rdata[NFLAGS-1:0] == '0
			|| $past(reg_addr) != ADDR_STATUS || $past(|flag_set));
	endproperty
	a_clear_flags: assert property (p_clear_flags) else $error("clear did not clear"); // R13

	property p_uv_latch;
		(q.pin[PIN_UV70] && q.pin[PIN_CURRENT_LIMIT_FLAG]) |=> q.flags[FLAG_UV] ##1 (q.flags[FLAG_UV] || $past(fault_clear_wr));
	endproperty
	a_uv_latch: assert property (p_uv_latch) else $error("output-low flag not set"); // R03

	property p_switch_off;
		!q.sw_en |=> !switch_allow;
	endproperty
	a_switch_off: assert property (p_switch_off) else $error("switches on while disabled"); // R12

	property p_dcm_shutdown;
		!switch_allow |-> status_word[STAT_DCM];
	endproperty
	a_dcm_shutdown: assert property (p_dcm_shutdown) else $error("dcm low in shutdown"); // R10

	property p_pg_delay;
		$rose(power_good) |-> (q.pg_tmr == pg_target) && $past(q.fb_seen);
	endproperty
	a_pg_delay: assert property (p_pg_delay) else $error("power good before delay"); // R09

	property p_pg_window;
		!q.pin[PIN_PGWIN] |=> !power_good;
	endproperty
	a_pg_window: assert property (p_pg_window) else $error("power good outside window"); // R11

	property p_dns_latch;
		(q.seq == SEQ_SOFT && q.tmr >= ss_target && !q.fb_seen && !q.pin[PIN_FB90])
			|=> q.flags[FLAG_DNS] && q.seq != SEQ_SOFT;
	endproperty
	a_dns_latch: assert property (p_dns_latch) else $error("failed start not flagged"); // R08

	property p_load_off;
		!q.il_en |-> !internal_load_on;
	endproperty
	a_load_off: assert property (p_load_off) else $error("pull-down on while disabled"); // R14

	property p_pod_end;
		(q.seq == SEQ_POD && q.tmr >= pod_target && start_ok) |=> soft_start_active;
	endproperty
	a_pod_end: assert property (p_pod_end) else $error("power-on delay did not end"); // R16

	property p_soft_hold;
		(q.seq == SEQ_SOFT && q.tmr < ss_target && start_ok) |=> soft_start_active;
	endproperty
	a_soft_hold: assert property (p_soft_hold) else $error("soft start ended early"); // R17

	property p_ss_longest;
		(ss_code > SST_MAXSHIFT) |-> (ss_steps == SST_LONGEST);
	endproperty
	a_ss_longest: assert property (p_ss_longest) else $error("soft-start code not longest"); // R20

	property p_pg_read;
		(reg_addr == ADDR_STATUS) |=> (reg_rdata[STAT_PG] == $past(power_good));
	endproperty
	a_pg_read: assert property (p_pg_read) else $error("power good status differs from output"); // R11

	property p_dcm_live;
		(reg_addr == ADDR_STATUS && q.seq == SEQ_RUN && !q.pin[PIN_DCM]) |=> !reg_rdata[STAT_DCM];
	endproperty
	a_dcm_live: assert property (p_dcm_live) else $error("dcm status stuck high"); // R01

	property p_clear_self;
		(reg_addr == ADDR_CTRL) |=> !reg_rdata[BIT_CLEAR];
	endproperty
	a_clear_self: assert property (p_clear_self) else $error("fault clear bit reads one"); // R13

	property p_freq_write;
		(reg_wr && reg_addr == ADDR_TIME_A) |=> (freq_select == 2'($past(reg_wdata)));
	endproperty
	a_freq_write: assert property (p_freq_write) else $error("frequency code not applied"); // R15

	property p_pg_shutdown;
		!switch_allow |=> !power_good;
	endproperty
	a_pg_shutdown: assert property (p_pg_shutdown) else $error("power good while switching off"); // R11
endmodule
`default_nettype wire

// *** bench/host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input  wire logic       clock,
	input  wire logic [7:0] reg_rdata,
	output logic            reg_wr,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata
);
	initial begin
		reg_wr = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// undefined soft-start code never sent
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= (a == 8'h03 && d[4:2] == 3'h6) ? (d | 8'h04) : d;
		@(posedge clock);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		repeat (2) @(posedge clock);
		#1 d = reg_rdata;
	endtask
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import buck_regs_pkg::*;
	logic       clock = 1'b0;
	logic       rst_b = 1'b0;
	logic [9:0] cond = 10'h000;
	logic       reg_wr;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
	logic       sw, ss, pg, il, lq, us;
	logic [1:0] fs, mf;
	logic [7:0] b2, b3;
	logic [9:0] pins [5] = '{10'h003, 10'h004, 10'h008, 10'h002, 10'h010};
	logic [7:0] flg [5] = '{8'h09, 8'h02, 8'h04, 8'h08, 8'h10};
	int         errors = 0, checked = 0, lf = 11, n;
	localparam int UNIT = 20;
	always #5 clock = ~clock;
	host_model host (.clock(clock), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata));
	buck_ctrl_status_timing_regs #(.UNIT_CYCLES(UNIT)) uut (.clock(clock), .rst_b(rst_b),
		.reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.out_below_70(cond[0]), .current_limit_hit(cond[1]), .out_above_120(cond[2]),
		.thermal_trip(cond[3]), .fb_below_80(cond[4]), .fb_above_90(cond[5]),
		.out_in_window(cond[6]), .zero_cross_dcm(cond[7]), .enable_pin(cond[8]),
		.slewing_down(cond[9]), .switch_allow(sw), .soft_start_active(ss), .power_good(pg),
		.internal_load_on(il), .freq_select(fs), .low_iq_power_save(lq),
		.ultrasonic_power_save(us), .ultrasonic_min_freq_select(mf));
	function automatic int lfsr(input int v);
		return int'({v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]});
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		host.rd(a, d);
		chk(d, exp);
	endtask
	task automatic pins_to(input logic [9:0] v);
		@(posedge clock);
		cond <= v;
		repeat (6) @(posedge clock);
	endtask
	task automatic give_verdict;
		$display("checked=%0d errors=%0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clock);
		errors++;
		give_verdict();
	end
	initial begin
		repeat (8) @(posedge clock);
		rst_b <= 1'b1;
		rchk(8'h00, 8'h40);
		rchk(8'h01, 8'h01);
		rchk(8'h02, 8'h20);
		rchk(8'h03, 8'h2e);
		rchk(8'h05, 8'h00);
		host.wr(8'h00, 8'hff);
		rchk(8'h00, 8'h40);
		$display("reset and map done");
		for (int i = 0; i < 5; i++) begin
			pins_to(pins[i]);
			pins_to(10'h000);
			rchk(8'h00, 8'h40 | flg[i]);
			host.wr(8'h01, 8'h03);
			rchk(8'h00, 8'h40);
		end
		rchk(8'h01, 8'h01);
		chk({7'h0, sw}, 8'h00);
		@(posedge clock);
		cond <= 10'h008;
		@(posedge clock);
		cond <= 10'h000;
		host.wr(8'h01, 8'h03);
		pins_to(10'h000);
		rchk(8'h00, 8'h44);
		host.wr(8'h01, 8'h03);
		$display("flags done");
		host.wr(8'h01, 8'hff);
		rchk(8'h01, 8'h05);
		pins_to(10'h200);
		chk({7'h0, il}, 8'h01);
		host.wr(8'h01, 8'h01);
		repeat (2) @(posedge clock);
		chk({7'h0, il}, 8'h00);
		for (int i = 0; i < 8; i++) begin
			lf = lfsr(lf);
			b2 = lf[7:0] & 8'h3f;
			lf = lfsr(lf);
			b3 = lf[7:0] & 8'h3f;
			if (b3[4:2] == 3'h6)
				b3[2] = 1'b1;
			host.wr(8'h02, b2);
			host.wr(8'h03, b3);
			rchk(8'h02, b2);
			rchk(8'h03, b3);
			chk({fs, lq, us, mf, 2'h0}, {b2[1:0], b3[1:0] == 2'h1, b3[1:0] == 2'h2,
				b3[5], b2[5], 2'h0});
		end
		$display("timing fields done");
		host.wr(8'h02, 8'h04);
		host.wr(8'h03, 8'h08);
		pins_to(10'h160);
		n = 0;
		while (!ss && n < 300) begin
			@(negedge clock);
			n++;
		end
		// sync, start and pod end, less the pins_to wait
		chk(8'(n), 8'(UNIT + 4 - 5));
		n = 0;
		while (!pg && n < 300) begin
			@(negedge clock);
			n++;
		end
		chk(8'(n), 8'(4 * UNIT / PG_DELAY_DIV + 2));
		while (ss && n < 300) begin
			@(negedge clock);
			n++;
		end
		chk(8'(n), 8'(4 * UNIT + 1));
		chk({7'h0, sw}, 8'h01);
		rchk(8'h00, 8'h80);
		host.wr(8'h03, 8'h09);
		pins_to(10'h1e0);
		rchk(8'h00, 8'hc0);
		pins_to(10'h120);
		rchk(8'h00, 8'h00);
		host.wr(8'h01, 8'h00);
		repeat (3) @(posedge clock);
		chk({7'h0, sw}, 8'h00);
		rchk(8'h00, 8'h40);
		pins_to(10'h100);
		host.wr(8'h01, 8'h01);
		repeat (150) @(posedge clock);
		rchk(8'h00, 8'h20);
		$display("sequencer done");
		give_verdict();
	end
endmodule
`default_nettype wire
